// ==== rtl/sleep_ctrl_defs.svh ====
// Register offsets, field positions, reset values for the sleep/wake/lockup controller
`ifndef SLEEP_CTRL_DEFS_SVH
`define SLEEP_CTRL_DEFS_SVH
`define OFF_CTRL 4'h0
`define OFF_STATUS 4'h4
`define OFF_MASK 4'h8
`define OFF_STATE 4'hC
`define CTRL_SLEEP_AFTER_HANDLER 1
`define CTRL_DEEP_SLEEP_SELECT 2
`define CTRL_EVENT_ON_PENDING 4
// Only the three control bits are storable
`define CTRL_WR_MASK 32'h0000_0016
`define CTRL_RESET 32'h0000_0000
`define IRQ_LOCKUP 0
`define IRQ_WAKE 1
`define IRQ_SLEEP 2
`define IRQ_BITS 3
`define PRIO_W 8
`define PRIO_HARD_FAULT 8'h01
`define PRIO_NMI 8'h00
`endif

// ==== rtl/sleep_ctrl_pkg.sv ====
// Types shared by the sleep/wake/lockup controller
package sleep_ctrl_pkg;
    typedef enum logic [2:0] {
        ST_RUN = 3'b000,
        ST_SLEEP = 3'b001,
        ST_DEEP = 3'b010,
        ST_LOCK = 3'b011,
        ST_LOCK_NMI = 3'b100
    } core_state_e;
    typedef enum logic [1:0] {
        CAUSE_NONE = 2'b00,
        CAUSE_INTR = 2'b01,
        CAUSE_EVENT = 2'b10,
        CAUSE_EXIT = 2'b11
    } sleep_cause_e;
    typedef logic [7:0] prio_t;
endpackage

// ==== rtl/axil_regs_if.sv ====
// Register bus carrier between AXI4-Lite slave and controller core
`timescale 1ns/1ps
interface axil_regs_if;
    logic wr_en;
    logic [3:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic [3:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_ok;
    logic wr_ok;
    modport slave (output wr_en, output wr_addr, output wr_data, output wr_strb,
        output rd_addr, input rd_data, input rd_ok, input wr_ok);
    modport core (input wr_en, input wr_addr, input wr_data, input wr_strb,
        input rd_addr, output rd_data, output rd_ok, output wr_ok);
endinterface // axil_regs_if

// ==== rtl/axil_slave.sv ====
// AXI4-Lite slave front end, one write and one read at a time
`timescale 1ns/1ps
module axil_slave (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [31:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [31:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    axil_regs_if.slave rb
);
    typedef struct packed {
        logic aw_have;
        logic [3:0] aw_addr;
        logic aw_bad;
        logic w_have;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic awready;
        logic wready;
        logic arready;
    } axs_s;
    axs_s st_reg;
    axs_s st_next;
    logic wr_fire;
    ////////////////////////////////////////////////////////////////
    always_comb begin
        st_next = st_reg;
        wr_fire = st_reg.aw_have && st_reg.w_have && !st_reg.bvalid;
        if (s_awvalid && !st_reg.aw_have) begin
            st_next.aw_have = 1'b1;
            st_next.aw_addr = s_awaddr[3:0];
            // Only word 0..3 exist; anything else answers SLVERR
            st_next.aw_bad = (s_awaddr[31:4] != 28'h000_0000) || (s_awaddr[1:0] != 2'b00);
        end
        if (s_wvalid && !st_reg.w_have) begin
            st_next.w_have = 1'b1;
            st_next.w_data = s_wdata;
            st_next.w_strb = s_wstrb;
        end
        if (wr_fire) begin
            st_next.aw_have = 1'b0;
            st_next.w_have = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp = (st_reg.aw_bad || !rb.wr_ok) ? 2'b10 : 2'b00;
        end
        if (st_reg.bvalid && s_bready) begin
            st_next.bvalid = 1'b0;
        end
        if (s_arvalid && !st_reg.rvalid) begin
            st_next.rvalid = 1'b1;
            // Out-of-range or unaligned reads answer zero with SLVERR
            if (rb.rd_ok && (s_araddr[31:4] == 28'h000_0000) && (s_araddr[1:0] == 2'b00)) begin
                st_next.rdata = rb.rd_data;
                st_next.rresp = 2'b00;
            end else begin
                st_next.rdata = 32'h0000_0000;
                st_next.rresp = 2'b10;
            end
        end else if (st_reg.rvalid && s_rready) begin
            st_next.rvalid = 1'b0;
        end
        // Readies registered so the ports come straight from flops
        st_next.awready = !st_next.aw_have;
        st_next.wready = !st_next.w_have;
        st_next.arready = !st_next.rvalid;
    end
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= '0;
            st_reg.awready <= 1'b1;
            st_reg.wready <= 1'b1;
            st_reg.arready <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end
    assign s_awready = st_reg.awready;
    assign s_wready = st_reg.wready;
    assign s_bvalid = st_reg.bvalid;
    assign s_bresp = st_reg.bresp;
    assign s_arready = st_reg.arready;
    assign s_rvalid = st_reg.rvalid;
    assign s_rdata = st_reg.rdata;
    assign s_rresp = st_reg.rresp;
    assign rb.wr_en = wr_fire && !st_reg.aw_bad;
    assign rb.wr_addr = st_reg.aw_addr;
    assign rb.wr_data = st_reg.w_data;
    assign rb.wr_strb = st_reg.w_strb;
    assign rb.rd_addr = s_araddr[3:0];
endmodule // axil_slave

// ==== rtl/core_sleep_wake_lockup_control.sv ====
// Sleep, wake and lockup controller for the processor core
//
// Summary of operation
// RL1 - Hard fault while in NMI or hard fault handler enters lockup.
// RL2 - No instruction fetch or execute while locked up.
// RL3 - Lockup ends on reset, NMI, or debugger halt.
// RL4 - Lockup entered from NMI handler ignores further NMIs.
// RL5 - Ordinary sleep gates the processor clock.
// RL6 - Deep sleep stops system clock, powers down PLL and flash.
// RL7 - Deep-sleep select bit chooses sleep or deep sleep.
// RL8 - Wait-for-interrupt sleeps at once, unconditionally; here a same-cycle NMI, hard fault or lockup entry is taken instead.
// RL9 - Wait-for-event with event register 0 sleeps.
// RL10 - Wait-for-event with event register 1 clears it, keeps running.
// RL11 - Sleep-after-handler set: handler completion returns then sleeps.
// RL12 - Interrupt or exit sleep wakes only on an entry-capable exception.
// RL13 - Priority mask set: higher interrupt wakes, handler held until cleared.
// RL14 - Event sleep wakes on exception, external event, or remote send-event.
// RL15 - Event-on-pending: any new pending interrupt makes a waking event.
// RL16 - External event wakes event sleep, or sets event register when awake.
// RL17 - Hard fault preempted only by reset and NMI.
//
// Added by the designer: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`include "sleep_ctrl_defs.svh"
module core_sleep_wake_lockup_control (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic wait_for_interrupt_instr,
    input wire logic wait_for_event_instr,
    input wire logic send_event_instr_remote,
    input wire logic handler_complete,
    input wire logic return_to_thread,
    input wire logic hard_fault,
    input wire logic nmi_req,
    input wire logic in_nmi_handler,
    input wire logic in_hard_fault_handler,
    input wire logic debug_halt,
    input wire logic ext_event,
    input wire logic irq_pend_new,
    input wire logic irq_enabled,
    input wire sleep_ctrl_pkg::prio_t irq_prio,
    input wire sleep_ctrl_pkg::prio_t cur_prio,
    input wire logic priority_mask_bit,
    input wire logic fault_mask_bit,
    input wire logic [31:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [31:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    output logic fetch_enable,
    output logic proc_clk_en,
    output logic sys_clk_en,
    output logic pll_power_en,
    output logic flash_power_en,
    output logic locked_up,
    output logic take_hard_fault,
    output logic take_nmi,
    output logic handler_held,
    output logic irq
);
    import sleep_ctrl_pkg::*;
    typedef struct packed {
        core_state_e state;
        sleep_cause_e cause;
        logic event_flag;
        logic [31:0] ctrl;
        logic [`IRQ_BITS-1:0] status;
        logic [`IRQ_BITS-1:0] mask;
        logic hold;
        logic fetch;
        logic pclk;
        logic sclk;
        logic pll;
        logic flash;
        logic lock_out;
        logic hf_out;
        logic nmi_out;
        logic irq_out;
    } ctrl_s;
    ctrl_s st_reg;
    ctrl_s st_next;
    axil_regs_if rb ();
    logic exc_wake;
    logic event_wake;
    logic go_sleep;
    logic [`IRQ_BITS-1:0] ev_set;
    logic [31:0] rd_mux;
    ////////////////////////////////////////////////////////////////
    axil_slave u_bus (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .s_awaddr(s_awaddr),
        .s_awvalid(s_awvalid),
        .s_awready(s_awready),
        .s_wdata(s_wdata),
        .s_wstrb(s_wstrb),
        .s_wvalid(s_wvalid),
        .s_wready(s_wready),
        .s_bresp(s_bresp),
        .s_bvalid(s_bvalid),
        .s_bready(s_bready),
        .s_araddr(s_araddr),
        .s_arvalid(s_arvalid),
        .s_arready(s_arready),
        .s_rdata(s_rdata),
        .s_rresp(s_rresp),
        .s_rvalid(s_rvalid),
        .s_rready(s_rready),
        .rb(rb.slave)
    );
    ////////////////////////////////////////////////////////////////
    // Read mux is combinational; the slave registers it
    always_comb begin
        case (rb.rd_addr)
            `OFF_CTRL: rd_mux = st_reg.ctrl;
            `OFF_STATUS: rd_mux = {29'h0000_0000, st_reg.status};
            `OFF_MASK: rd_mux = {29'h0000_0000, st_reg.mask};
            `OFF_STATE: rd_mux = {27'h000_0000, st_reg.event_flag, 1'b0, st_reg.state};
            default: rd_mux = 32'h0000_0000;
        endcase
    end
    assign rb.rd_data = rd_mux;
    assign rb.rd_ok = 1'b1;
    assign rb.wr_ok = 1'b1;
    ////////////////////////////////////////////////////////////////
    // Priority mask blocks entry but not wake; fault mask set blocks both
    always_comb begin
        exc_wake = nmi_req || hard_fault
            || (irq_pend_new && irq_enabled && (irq_prio < cur_prio) && !fault_mask_bit); // RL12 RL13
        event_wake = exc_wake || ext_event || send_event_instr_remote
            || (irq_pend_new && st_reg.ctrl[`CTRL_EVENT_ON_PENDING]); // RL14 RL15 RL16
    end
    ////////////////////////////////////////////////////////////////
    always_comb begin
        st_next = st_reg;
        ev_set = '0;
        go_sleep = 1'b0;
        st_next.hf_out = 1'b0;
        st_next.nmi_out = 1'b0;
        case (st_reg.state)
            ST_RUN: begin
                if (hard_fault && (in_nmi_handler || in_hard_fault_handler)) begin
                    st_next.state = in_nmi_handler ? ST_LOCK_NMI : ST_LOCK; // RL1 RL4
                    ev_set[`IRQ_LOCKUP] = 1'b1;
                end else if (nmi_req) begin
                    st_next.nmi_out = 1'b1; // RL17
                end else if (hard_fault) begin
                    st_next.hf_out = 1'b1; // RL17
                end else if (wait_for_interrupt_instr) begin
                    go_sleep = 1'b1; // RL8
                    st_next.cause = CAUSE_INTR;
                end else if (wait_for_event_instr) begin
                    if (st_reg.event_flag || ext_event || send_event_instr_remote) begin
                        st_next.event_flag = 1'b0; // RL10
                    end else begin
                        go_sleep = 1'b1; // RL9
                        st_next.cause = CAUSE_EVENT;
                    end
                end else if (handler_complete && return_to_thread
                    && st_reg.ctrl[`CTRL_SLEEP_AFTER_HANDLER]) begin
                    go_sleep = 1'b1; // RL11
                    st_next.cause = CAUSE_EXIT;
                end
                if (go_sleep) begin
                    st_next.state = st_reg.ctrl[`CTRL_DEEP_SLEEP_SELECT] ? ST_DEEP : ST_SLEEP; // RL7
                    ev_set[`IRQ_SLEEP] = 1'b1;
                end
                // Event seen while awake arms the next wait-for-event
                if ((ext_event || send_event_instr_remote) && !wait_for_event_instr) begin
                    st_next.event_flag = 1'b1; // RL16
                end
            end
            ST_SLEEP, ST_DEEP: begin
                if ((st_reg.cause == CAUSE_EVENT) ? event_wake : exc_wake) begin // RL12 RL14
                    st_next.state = ST_RUN;
                    st_next.cause = CAUSE_NONE;
                    ev_set[`IRQ_WAKE] = 1'b1;
                    // Wake with mask set defers the handler
                    st_next.hold = priority_mask_bit && !fault_mask_bit; // RL13
                end
            end
            ST_LOCK: begin
                if (debug_halt || nmi_req) begin
                    st_next.state = ST_RUN; // RL3
                    st_next.nmi_out = nmi_req;
                end
            end
            ST_LOCK_NMI: begin
                if (debug_halt) begin
                    st_next.state = ST_RUN; // RL4
                end
            end
            default: st_next.state = ST_RUN;
        endcase
        if (!priority_mask_bit) begin
            st_next.hold = 1'b0; // RL13
        end
        if (rb.wr_en && rb.wr_strb[0]) begin
            case (rb.wr_addr)
                `OFF_CTRL: st_next.ctrl = rb.wr_data & `CTRL_WR_MASK; // RL7 RL11 RL15
                `OFF_STATUS: st_next.status = st_reg.status & ~rb.wr_data[`IRQ_BITS-1:0];
                `OFF_MASK: st_next.mask = rb.wr_data[`IRQ_BITS-1:0];
                default: st_next.mask = st_reg.mask;
            endcase
        end
        // Set wins over a same-cycle write-one-to-clear
        st_next.status = st_next.status | ev_set;
        st_next.fetch = (st_next.state == ST_RUN); // RL2
        st_next.pclk = !(st_next.state == ST_SLEEP || st_next.state == ST_DEEP); // RL5
        st_next.sclk = (st_next.state != ST_DEEP); // RL6
        st_next.pll = (st_next.state != ST_DEEP); // RL6
        st_next.flash = (st_next.state != ST_DEEP); // RL6
        st_next.lock_out = (st_next.state == ST_LOCK) || (st_next.state == ST_LOCK_NMI);
        st_next.irq_out = |(st_next.status & st_next.mask);
    end
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= '0;
            st_reg.ctrl <= `CTRL_RESET;
            st_reg.fetch <= 1'b1;
            st_reg.pclk <= 1'b1;
            st_reg.sclk <= 1'b1;
            st_reg.pll <= 1'b1;
            st_reg.flash <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end
    assign fetch_enable = st_reg.fetch;
    assign proc_clk_en = st_reg.pclk;
    assign sys_clk_en = st_reg.sclk;
    assign pll_power_en = st_reg.pll;
    assign flash_power_en = st_reg.flash;
    assign locked_up = st_reg.lock_out;
    assign take_hard_fault = st_reg.hf_out;
    assign take_nmi = st_reg.nmi_out;
    assign handler_held = st_reg.hold;
    assign irq = st_reg.irq_out;
endmodule // core_sleep_wake_lockup_control

// ==== tb/event_source_model.sv ====
// Peripheral and second core model driving the event inputs
`timescale 1ns/1ps
module event_source_model (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic want_ext,
    input wire logic want_remote,
    output logic ext_event,
    output logic send_event_instr_remote
);
    // Registered copies of want_ext and want_remote, one cycle late, never glitching into the core
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ext_event <= 1'b0;
            send_event_instr_remote <= 1'b0;
        end else begin
            ext_event <= want_ext;
            send_event_instr_remote <= want_remote;
        end
    end
endmodule // event_source_model

// ==== tb/core_sleep_wake_lockup_control_checker.sv ====
// Concurrent checks on the sleep, wake and lockup controller ports
`timescale 1ns/1ps
module core_sleep_wake_lockup_control_checker (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic wait_for_interrupt_instr,
    input wire logic wait_for_event_instr,
    input wire logic hard_fault,
    input wire logic nmi_req,
    input wire logic in_nmi_handler,
    input wire logic in_hard_fault_handler,
    input wire logic debug_halt,
    input wire logic ext_event,
    input wire logic irq_pend_new,
    input wire logic priority_mask_bit,
    input wire logic fetch_enable,
    input wire logic proc_clk_en,
    input wire logic sys_clk_en,
    input wire logic pll_power_en,
    input wire logic flash_power_en,
    input wire logic locked_up,
    input wire logic take_hard_fault,
    input wire logic handler_held
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    sequence s_evt_slept;
        wait_for_event_instr ##1 (!fetch_enable && !locked_up);
    endsequence
    sequence s_intr_slept;
        wait_for_interrupt_instr ##1 (!fetch_enable && !locked_up);
    endsequence
    sequence s_nmi_lock;
        hard_fault && in_nmi_handler && !locked_up && !debug_halt;
    endsequence
    lock_entry_a: assert property (hard_fault && (in_nmi_handler || in_hard_fault_handler)
        && !debug_halt && !nmi_req |=> locked_up) else $error("no lockup");
    lock_nofetch_a: assert property (locked_up |-> !fetch_enable) else $error("fetch in lockup");
    halt_release_a: assert property (locked_up && debug_halt |=> !locked_up) else $error("halt");
    nmi_ignored_a: assert property (s_nmi_lock ##1 (!debug_halt) [*4] |-> locked_up)
        else $error("nmi left lockup");
    intr_sleep_a: assert property (wait_for_interrupt_instr && fetch_enable && !irq_pend_new
        && !nmi_req && !hard_fault && !debug_halt |=> !fetch_enable && !proc_clk_en)
        else $error("sleep instruction ignored");
    deep_power_a: assert property (!sys_clk_en |-> !pll_power_en && !flash_power_en
        && !proc_clk_en) else $error("deep sleep power");
    event_skip_a: assert property (fetch_enable && ext_event ##[1:3] (wait_for_event_instr
        && fetch_enable && !irq_pend_new) |=> fetch_enable) else $error("event flag ignored");
    event_wake_a: assert property (s_evt_slept ##[0:4] (ext_event && !fetch_enable)
        |=> fetch_enable) else $error("no event wake");
    intr_hold_a: assert property (s_intr_slept ##[0:8] (ext_event && !fetch_enable
        && !irq_pend_new && !nmi_req && !debug_halt && !hard_fault) |=> !fetch_enable)
        else $error("woke on event");
    fault_prio_a: assert property (hard_fault && fetch_enable && !in_nmi_handler
        && !in_hard_fault_handler && !nmi_req |=> take_hard_fault) else $error("fault");
    held_release_a: assert property (handler_held && !priority_mask_bit |=> !handler_held)
        else $error("held");
endmodule // core_sleep_wake_lockup_control_checker
bind core_sleep_wake_lockup_control core_sleep_wake_lockup_control_checker u_chk (
    .clk_sys, .arst_n, .wait_for_interrupt_instr, .wait_for_event_instr, .hard_fault,
    .nmi_req, .in_nmi_handler, .in_hard_fault_handler, .debug_halt, .ext_event,
    .irq_pend_new, .priority_mask_bit, .fetch_enable, .proc_clk_en, .sys_clk_en,
    .pll_power_en, .flash_power_en, .locked_up, .take_hard_fault, .handler_held);

// ==== tb/core_sleep_wake_lockup_control_tb.sv ====
// Self-checking bench for the sleep, wake and lockup controller
`timescale 1ns/1ps
`include "sleep_ctrl_defs.svh"
module core_sleep_wake_lockup_control_tb;
import sleep_ctrl_pkg::*;
localparam logic [6:0] P_INTR = 7'h01, P_EVT = 7'h02, P_EXIT = 7'h04, P_HF = 7'h08;
localparam logic [6:0] P_NMI = 7'h10, P_IRQ = 7'h20, P_HALT = 7'h40;
localparam logic [5:0] O_RUN = 6'h3e, O_SLP = 6'h0e, O_DEEP = 6'h00, O_LOCK = 6'h1f;
logic clk_sys = 1'b0;
logic arst_n = 1'b0;
logic [6:0] pul = '0;
logic want_ext = 1'b0, want_remote = 1'b0, in_nmi_handler = 1'b0, in_hard_fault_handler = 1'b0;
logic irq_enabled = 1'b1, priority_mask_bit = 1'b0, fault_mask_bit = 1'b0;
prio_t irq_prio = 8'h00, cur_prio = 8'hff;
logic [31:0] s_awaddr = '0, s_wdata = '0, s_araddr = '0, s_rdata;
logic [3:0] s_wstrb = '0;
logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, ext_event, send_event_instr_remote;
logic [1:0] s_bresp, s_rresp, bresp_seen;
logic fetch_enable, proc_clk_en, sys_clk_en, pll_power_en, flash_power_en, locked_up;
logic take_hard_fault, take_nmi, handler_held, irq;
wire wait_for_interrupt_instr = pul[0];
wire wait_for_event_instr = pul[1];
wire handler_complete = pul[2];
wire return_to_thread = pul[2];
wire hard_fault = pul[3];
wire nmi_req = pul[4];
wire irq_pend_new = pul[5];
wire debug_halt = pul[6];
int n_errors = 0;
int num_checks = 0;
int cyc = 0;
always #2.5 clk_sys = ~clk_sys;
event_source_model u_src (.clk_sys, .arst_n, .want_ext, .want_remote, .ext_event,
    .send_event_instr_remote);
core_sleep_wake_lockup_control dut (.clk_sys, .arst_n, .wait_for_interrupt_instr,
    .wait_for_event_instr, .send_event_instr_remote, .handler_complete, .return_to_thread,
    .hard_fault, .nmi_req, .in_nmi_handler, .in_hard_fault_handler, .debug_halt, .ext_event,
    .irq_pend_new, .irq_enabled, .irq_prio, .cur_prio, .priority_mask_bit, .fault_mask_bit,
    .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp,
    .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid,
    .s_rready, .fetch_enable, .proc_clk_en, .sys_clk_en, .pll_power_en, .flash_power_en,
    .locked_up, .take_hard_fault, .take_nmi, .handler_held, .irq);
////////////////////////////////////////////////////////////////////////////////
function automatic logic exp_wake(input prio_t i, input prio_t c);
    return i < c;
endfunction
task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
        n_errors++;
        $display("wrong value %s expected %h seen %h", nm, e, g);
    end
endtask
task automatic chk_outs(input string nm, input logic [5:0] e);
    chk_word(nm, 32'(e), 32'({fetch_enable, proc_clk_en, sys_clk_en, pll_power_en,
        flash_power_en, locked_up}));
endtask
task automatic complete_run;
    if (n_errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
endtask
task automatic pulse(input logic [6:0] p);
    @(posedge clk_sys);
    pul <= p;
    @(posedge clk_sys);
    pul <= '0;
    #1;
endtask
task automatic fire(input logic e, input logic s);
    @(posedge clk_sys);
    want_ext <= e;
    want_remote <= s;
    @(posedge clk_sys);
    want_ext <= 1'b0;
    want_remote <= 1'b0;
    @(posedge clk_sys);
    #1;
endtask
// Handshakes judged at the falling edge, acted on at the next rising edge
task automatic axw(input logic [31:0] a, input logic [31:0] d);
    logic ha, hw, hb;
    @(posedge clk_sys);
    s_awaddr <= a;
    s_wdata <= d;
    s_wstrb <= 4'hf;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do begin
        @(negedge clk_sys);
        ha = s_awvalid && s_awready;
        hw = s_wvalid && s_wready;
        hb = s_bvalid;
        bresp_seen = s_bresp;
        @(posedge clk_sys);
        if (ha) s_awvalid <= 1'b0;
        if (hw) s_wvalid <= 1'b0;
    end while (!hb);
    s_bready <= 1'b0;
endtask
task automatic axr(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ha, hr;
    @(posedge clk_sys);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do begin
        @(negedge clk_sys);
        ha = s_arvalid && s_arready;
        hr = s_rvalid;
        d = s_rdata;
        r = s_rresp;
        @(posedge clk_sys);
        if (ha) s_arvalid <= 1'b0;
    end while (!hr);
    s_rready <= 1'b0;
endtask
always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
        n_errors++;
        complete_run();
    end
end
////////////////////////////////////////////////////////////////////////////////
initial begin
    logic [31:0] d;
    logic [1:0] r;
    prio_t ip, cp;
    void'($urandom(32'hff7dc731));
    repeat (20) @(posedge clk_sys);
    arst_n <= 1'b1;
    axr(32'(`OFF_CTRL), d, r);
    chk_word("ctrl", `CTRL_RESET, d);
    axr(32'h0000_0010, d, r);
    chk_word("bad_resp", 32'h2, 32'(r));
    chk_word("bad_data", 32'h0, d);
    axw(32'h0000_0010, 32'hffff_ffff);
    chk_word("bad_wresp", 32'h2, 32'(bresp_seen));
    axr(32'(`OFF_CTRL), d, r);
    chk_word("ctrl_kept", `CTRL_RESET, d);
    chk_outs("run", O_RUN);
    pulse(P_HF);
    chk_word("take_hf", 32'h1, 32'(take_hard_fault));
    for (int k = 0; k < 2; k++) begin
        axw(32'(`OFF_CTRL), 32'(k) << `CTRL_DEEP_SLEEP_SELECT);
        chk_word("wresp", 32'h0, 32'(bresp_seen));
        pulse(P_INTR);
        chk_outs("intr_sleep", k ? O_DEEP : O_SLP);
        axr(32'(`OFF_STATE), d, r);
        chk_word("state", 32'(k + 1), d & 32'h7);
        fire(1'b1, 1'b0);
        chk_outs("intr_ext", k ? O_DEEP : O_SLP);
        pulse(P_IRQ);
        chk_outs("intr_irq", O_RUN);
    end
    axw(32'(`OFF_CTRL), 32'h0);
    for (int k = 0; k < 6; k++) begin
        ip = k ? 8'($urandom) : 8'h40;
        cp = k ? 8'($urandom) : 8'h40;
        @(posedge clk_sys);
        irq_prio <= ip;
        cur_prio <= cp;
        pulse(P_INTR);
        pulse(P_IRQ);
        chk_word("prio_wake", 32'(exp_wake(ip, cp)), 32'(fetch_enable));
        @(posedge clk_sys);
        irq_prio <= 8'h00;
        cur_prio <= 8'hff;
        pulse(P_IRQ);
    end
    @(posedge clk_sys);
    priority_mask_bit <= 1'b1;
    pulse(P_INTR);
    pulse(P_IRQ);
    chk_word("held", 32'h3, 32'({fetch_enable, handler_held}));
    @(posedge clk_sys);
    priority_mask_bit <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk_word("held_off", 32'h0, 32'(handler_held));
    axw(32'(`OFF_CTRL), 32'h1 << `CTRL_SLEEP_AFTER_HANDLER);
    pulse(P_EXIT);
    chk_outs("exit", O_SLP);
    pulse(P_IRQ);
    chk_outs("exit_wake", O_RUN);
    axw(32'(`OFF_CTRL), 32'h0);
    for (int k = 0; k < 2; k++) begin
        fire(1'b1, 1'b0);
        pulse(P_EVT);
        chk_outs("evt_set", O_RUN);
        pulse(P_EVT);
        chk_outs("evt_clr", O_SLP);
        fire(k == 1, k == 0);
        chk_outs("evt_wake", O_RUN);
    end
    @(posedge clk_sys);
    irq_enabled <= 1'b0;
    pulse(P_EVT);
    pulse(P_IRQ);
    chk_outs("pend_off", O_SLP);
    axw(32'(`OFF_CTRL), 32'h1 << `CTRL_EVENT_ON_PENDING);
    axr(32'(`OFF_CTRL), d, r);
    chk_word("ctrl_pend", 32'h10, d);
    pulse(P_IRQ);
    chk_outs("pend_on", O_RUN);
    axw(32'(`OFF_MASK), 32'h1 << `IRQ_SLEEP);
    repeat (2) @(posedge clk_sys);
    #1;
    chk_word("irq_on", 32'h1, 32'(irq));
    axw(32'(`OFF_STATUS), 32'h1 << `IRQ_SLEEP);
    axr(32'(`OFF_STATUS), d, r);
    chk_word("status", 32'h0, d & 32'h4);
    chk_word("irq_off", 32'h0, 32'(irq));
    @(posedge clk_sys);
    in_hard_fault_handler <= 1'b1;
    pulse(P_HF);
    chk_outs("lock_hf", O_LOCK);
    pulse(P_NMI);
    chk_word("nmi_exit", 32'h3, 32'({locked_up, fetch_enable, take_nmi}));
    @(posedge clk_sys);
    in_hard_fault_handler <= 1'b0;
    in_nmi_handler <= 1'b1;
    pulse(P_HF);
    pulse(P_NMI);
    chk_outs("lock_nmi", O_LOCK);
    axr(32'(`OFF_STATE), d, r);
    chk_word("lock_state", 32'h4, d & 32'h7);
    pulse(P_HALT);
    chk_outs("halt_exit", O_RUN);
    complete_run();
end
endmodule // core_sleep_wake_lockup_control_tb
